//--- design/sbcm_consts.vh
// Constants for the operating-mode controller: offsets, fields, reset values, timing
`ifndef SBCM_CONSTS_VH
`define SBCM_CONSTS_VH

// ----------------------------------------
// Clock and timing
// ----------------------------------------
`define SBCM_CLK_PERIOD_NS 50
`define SBCM_T_LW_US 100000
`define SBCM_T_RD_US 10
`define SBCM_T_CFGF_US 2
`define SBCM_T_WD_US 20000

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define SBCM_ADDR_MODE_CTRL 4'h0
`define SBCM_ADDR_HW_CTRL0 4'h1
`define SBCM_ADDR_STATUS 4'h2
`define SBCM_ADDR_WAKE_LVL 4'h3
`define SBCM_ADDR_DEV_STAT 4'h4
`define SBCM_ADDR_WD_TRIG 4'h5

// ----------------------------------------
// Field positions
// ----------------------------------------
`define SBCM_HW_FCS 0
`define SBCM_HW_OVEN 1
`define SBCM_HW_LOCK0 2
`define SBCM_HW_LOCK1 3
`define SBCM_ST_POR 0
`define SBCM_ST_OV 1
`define SBCM_ST_WARN 2
`define SBCM_ST_UV 3
`define SBCM_ST_VSUV 4
`define SBCM_ST_FAIL 5
`define SBCM_WL_STRAP 0
`define SBCM_WL_DEV 1

// ----------------------------------------
// Mode codes and reset values
// ----------------------------------------
`define SBCM_MODE_NORMAL 2'h0
`define SBCM_MODE_SLEEP 2'h1
`define SBCM_MODE_STOP 2'h2
`define SBCM_MODE_SOFTRST 2'h3
`define SBCM_RST_FCS 1'h0
`define SBCM_RST_OVEN 1'h0
`define SBCM_SPI_BITS 5'h10

`endif

//--- design/sbcm_mode_ctrl.v
// Operating-mode controller with strap capture, watchdog and serial frame detection
//
// Our own choices: the register addresses and the strobed register port.
`timescale 1ns/1ps
`include "sbcm_consts.vh"

// Summary of operation
// - Six modes: init, normal, stop, sleep, restart, fail-safe
// - Restart waits failure clear, reset delay, normal
// - Fail-safe: regulator off, leave on wake/temperature
// - Development: watchdog halted, CAN normal, aux on
// - Serial link uses 16-bit words
// - Mode field cleared passing through restart
// - Power-up enters init; long window after release
// - Weak pull-down, filtered strap, latch on release
// - Power-on flag set: relatch every reset phase
// - Unstable strap keeps last; none gives zero
// - Warning and undervoltage flags update only after first release; overvoltage flag any time
// - Strap one: watchdog failure gives restart
// - Strap zero: fail-safe; first failure may restart
// - Overvoltage enabled: flag, fail, restart/fail-safe
// - Count select and strap state readable
// - Configuration changes only while unlocked; lock zero written only in normal
// - Any complete frame in init gives normal
// - Host triggers watchdog in long window
// - Missed long-window trigger in init gives failure, restart
// - Wake events ignored in init
// - Mode code 11 soft reset, locked bits kept
module sbcm_mode_ctrl #(
	parameter CW = 24,
	parameter LW_CYC = (`SBCM_T_LW_US * 1000) / `SBCM_CLK_PERIOD_NS,
	parameter WD_CYC = (`SBCM_T_WD_US * 1000) / `SBCM_CLK_PERIOD_NS,
	parameter RD_CYC = (`SBCM_T_RD_US * 1000 + `SBCM_CLK_PERIOD_NS - 1) / `SBCM_CLK_PERIOD_NS,
	parameter CF_CYC = (`SBCM_T_CFGF_US * 1000 + `SBCM_CLK_PERIOD_NS - 1) / `SBCM_CLK_PERIOD_NS
) (
	input wire sys_clk,
	input wire rst,
	input wire [3:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [7:0] reg_rdata_q,
	input wire irq_low_pin_in,
	output reg irq_low_pin_out_q,
	output reg irq_low_pin_oe_n_q,
	input wire test_pin,
	input wire main_uv_pin,
	input wire main_warn_pin,
	input wire batt_uv_pin,
	input wire main_ov_pin,
	input wire overtemp_pin,
	input wire wake_can_pin,
	input wire wake_input_pin,
	input wire wake_gpio_pin,
	input wire spi_clk_pin,
	input wire spi_cs_n_pin,
	input wire spi_mosi_pin,
	output reg spi_miso_q,
	output reg reset_out_low_pin_q,
	output reg fail_output_q,
	output reg main_regulator_en_q,
	output reg aux_regulator_en_q,
	output reg can_force_normal_q,
	output reg wd_halted_q,
	output reg [2:0] mode_state_q
);

	// ----------------------------------------
	// State codes
	// ----------------------------------------
	localparam [2:0] ST_INIT = 3'h0;
	localparam [2:0] ST_NORMAL = 3'h1;
	localparam [2:0] ST_STOP = 3'h2;
	localparam [2:0] ST_SLEEP = 3'h3;
	localparam [2:0] ST_RESTART = 3'h4;
	localparam [2:0] ST_FAILSAFE = 3'h5;
	localparam NSYNC = 13;
	localparam [NSYNC-1:0] SYNC_IDLE = 13'h0800; // Select line idles high, no false frame

	// ----------------------------------------
	// Input synchronisers
	// ----------------------------------------
	wire [NSYNC-1:0] pins_raw; // Asynchronous pins gathered
	reg [NSYNC-1:0] sync1_q; // First stage, read only by second
	reg [NSYNC-1:0] sync2_q; // Usable synchronised levels
	assign pins_raw = {spi_mosi_pin, spi_cs_n_pin, spi_clk_pin, wake_gpio_pin,
		wake_input_pin, wake_can_pin, overtemp_pin, main_ov_pin, batt_uv_pin,
		main_warn_pin, main_uv_pin, test_pin, irq_low_pin_in};

	// Two flip-flops per pin
	always @(posedge sys_clk) begin
		if (rst) begin
			sync1_q <= SYNC_IDLE;
			sync2_q <= SYNC_IDLE;
		end else begin
			sync1_q <= pins_raw;
			sync2_q <= sync1_q;
		end
	end

	wire irq_s = sync2_q[0]; // Strap sense level
	wire test_s = sync2_q[1]; // Development select
	wire uv_s = sync2_q[2]; // Main below reset threshold
	wire warn_s = sync2_q[3]; // Main supply warning
	wire vsuv_s = sync2_q[4]; // Battery undervoltage
	wire ov_s = sync2_q[5]; // Main overvoltage
	wire ot_s = sync2_q[6]; // Overtemperature
	wire wake_s = sync2_q[7] | sync2_q[8] | sync2_q[9]; // Any wake source
	wire sclk_s = sync2_q[10];
	wire cs_n_s = sync2_q[11];
	wire mosi_s = sync2_q[12];

	// ----------------------------------------
	// Serial frame detection
	// ----------------------------------------
	reg sclk_d1_q; // Previous serial clock
	reg cs_d1_q; // Previous select
	reg [4:0] bit_cnt_q; // Bits in current frame
	reg [15:0] shreg_q; // Outgoing status word
	reg frame_done_q; // Complete frame pulse
	reg strap_q; // Latched configuration strap
	reg dev_mode_q; // Development mode latched
	wire sclk_rise = sclk_s & ~sclk_d1_q;
	wire sclk_fall = ~sclk_s & sclk_d1_q;

	// Count bits, flag frame at select release
	always @(posedge sys_clk) begin
		if (rst) begin
			sclk_d1_q <= 1'b0;
			cs_d1_q <= 1'b1;
			bit_cnt_q <= 5'h00;
			shreg_q <= 16'h0000;
			frame_done_q <= 1'b0;
			spi_miso_q <= 1'b0;
		end else begin
			sclk_d1_q <= sclk_s;
			cs_d1_q <= cs_n_s;
			frame_done_q <= 1'b0;
			if (cs_n_s) begin
				// Only whole 16-bit words count as a frame
				if (!cs_d1_q)
					frame_done_q <= (bit_cnt_q == `SBCM_SPI_BITS);
				bit_cnt_q <= 5'h00;
				shreg_q <= {5'h00, mode_state_q, 6'h00, dev_mode_q, strap_q};
			end else begin
				if (sclk_rise && bit_cnt_q <= `SBCM_SPI_BITS)
					bit_cnt_q <= bit_cnt_q + 5'h01;
				if (sclk_fall)
					shreg_q <= {shreg_q[14:0], mosi_s};
				spi_miso_q <= shreg_q[15];
			end
		end
	end

	// ----------------------------------------
	// Control and status registers
	// ----------------------------------------
	reg [1:0] mode_field_q; // Requested mode field
	reg fcs_q; // Failure-count select
	reg ov_en_q; // Overvoltage reset enable
	reg lock0_q; // Configuration lock zero
	reg lock1_q; // Sticky lock one
	reg por_flag_q; // Power-on flag
	reg ov_flag_q; // Overvoltage flag
	reg warn_flag_q; // Main supply warning flag
	reg uv_flag_q; // Main undervoltage flag
	reg vsuv_flag_q; // Battery undervoltage flag
	reg released_q; // Reset released once
	reg [1:0] wd_fails_q; // Watchdog failures seen
	reg [2:0] state_q; // Current mode
	reg [CW-1:0] rd_cnt_q; // Reset delay counter
	reg [CW-1:0] wd_cnt_q; // Watchdog counter
	reg lw_q; // Long open window active
	reg fs_by_ot_q; // Fail-safe caused by temperature
	reg [CW-1:0] flt_cnt_q; // Strap filter counter
	reg flt_val_q; // Last filtered strap level
	reg flt_ok_q; // Filtered value exists
	reg flt_cand_q; // Level being timed
	reg ov_d1_q; // Previous overvoltage level

	wire wr_mode = reg_wr && reg_addr == `SBCM_ADDR_MODE_CTRL;
	wire wr_hw = reg_wr && reg_addr == `SBCM_ADDR_HW_CTRL0;
	wire wr_st = reg_wr && reg_addr == `SBCM_ADDR_STATUS;
	wire wd_trig = reg_wr && reg_addr == `SBCM_ADDR_WD_TRIG;
	wire ov_rise = ov_s & ~ov_d1_q;
	wire wd_run = reset_out_low_pin_q && !dev_mode_q && (state_q == ST_INIT ||
		state_q == ST_NORMAL || state_q == ST_STOP);
	wire wd_limit = lw_q ? (wd_cnt_q >= LW_CYC[CW-1:0]) : (wd_cnt_q >= WD_CYC[CW-1:0]);
	wire wd_fail = wd_run && wd_limit;
	wire [1:0] fails_nx = (wd_fails_q == 2'h2) ? 2'h2 : wd_fails_q + 2'h1;
	wire strap_phase = !reset_out_low_pin_q && (state_q == ST_INIT || por_flag_q);
	wire locked = lock0_q | lock1_q;

	// Register reads, data one cycle later
	always @(posedge sys_clk) begin
		if (rst) begin
			reg_rdata_q <= 8'h00;
		end else if (reg_rd) begin
			if (reg_addr == `SBCM_ADDR_MODE_CTRL)
				reg_rdata_q <= {6'h00, mode_field_q};
			else if (reg_addr == `SBCM_ADDR_HW_CTRL0)
				reg_rdata_q <= {4'h0, lock1_q, lock0_q, ov_en_q, fcs_q};
			else if (reg_addr == `SBCM_ADDR_STATUS)
				reg_rdata_q <= {2'h0, fail_output_q, vsuv_flag_q, uv_flag_q,
					warn_flag_q, ov_flag_q, por_flag_q};
			else if (reg_addr == `SBCM_ADDR_WAKE_LVL)
				reg_rdata_q <= {6'h00, dev_mode_q, strap_q};
			else if (reg_addr == `SBCM_ADDR_DEV_STAT)
				reg_rdata_q <= {3'h0, wd_fails_q, state_q};
			else
				reg_rdata_q <= 8'h00;
		end else begin
			reg_rdata_q <= 8'h00;
		end
	end

	// ----------------------------------------
	// Strap filter
	// ----------------------------------------
	// Level must hold for the filter time to count
	always @(posedge sys_clk) begin
		if (rst) begin
			flt_cnt_q <= {CW{1'b0}};
			flt_cand_q <= 1'b0;
			flt_val_q <= 1'b0;
			flt_ok_q <= 1'b0;
		end else if (!strap_phase) begin
			flt_cnt_q <= {CW{1'b0}};
		end else if (irq_s != flt_cand_q) begin
			// Level moved: restart timing, last filtered value kept
			flt_cand_q <= irq_s;
			flt_cnt_q <= {CW{1'b0}};
		end else if (flt_cnt_q >= CF_CYC[CW-1:0]) begin
			flt_val_q <= flt_cand_q;
			flt_ok_q <= 1'b1;
		end else begin
			flt_cnt_q <= flt_cnt_q + {{(CW-1){1'b0}}, 1'b1};
		end
	end

	// Weak pull-down on the interrupt pin in the strap phase
	always @(posedge sys_clk) begin
		if (rst) begin
			irq_low_pin_out_q <= 1'b0;
			irq_low_pin_oe_n_q <= 1'b0;
		end else begin
			irq_low_pin_out_q <= 1'b0;
			irq_low_pin_oe_n_q <= !strap_phase;
		end
	end

	// ----------------------------------------
	// Mode state machine
	// ----------------------------------------
	always @(posedge sys_clk) begin
		if (rst) begin
			state_q <= ST_INIT;
			mode_field_q <= `SBCM_MODE_NORMAL;
			fcs_q <= `SBCM_RST_FCS;
			ov_en_q <= `SBCM_RST_OVEN;
			lock0_q <= 1'b0;
			lock1_q <= 1'b0;
			por_flag_q <= 1'b1;
			ov_flag_q <= 1'b0;
			warn_flag_q <= 1'b0;
			uv_flag_q <= 1'b0;
			vsuv_flag_q <= 1'b0;
			strap_q <= 1'b0;
			dev_mode_q <= 1'b0;
			released_q <= 1'b0;
			wd_fails_q <= 2'h0;
			rd_cnt_q <= {CW{1'b0}};
			wd_cnt_q <= {CW{1'b0}};
			lw_q <= 1'b1;
			fs_by_ot_q <= 1'b0;
			ov_d1_q <= 1'b0;
			reset_out_low_pin_q <= 1'b0;
			fail_output_q <= 1'b0;
		end else begin
			ov_d1_q <= ov_s;
			// Host writes; hardware sets below win
			if (wr_hw) begin
				if (!locked) begin
					fcs_q <= reg_wdata[`SBCM_HW_FCS];
					ov_en_q <= reg_wdata[`SBCM_HW_OVEN];
				end
				if (state_q == ST_NORMAL)
					lock0_q <= reg_wdata[`SBCM_HW_LOCK0];
				lock1_q <= lock1_q | reg_wdata[`SBCM_HW_LOCK1];
			end
			if (wr_st) begin
				if (reg_wdata[`SBCM_ST_POR])
					por_flag_q <= 1'b0;
				if (reg_wdata[`SBCM_ST_OV])
					ov_flag_q <= 1'b0;
				if (reg_wdata[`SBCM_ST_WARN])
					warn_flag_q <= 1'b0;
				if (reg_wdata[`SBCM_ST_UV])
					uv_flag_q <= 1'b0;
				if (reg_wdata[`SBCM_ST_VSUV])
					vsuv_flag_q <= 1'b0;
				if (reg_wdata[`SBCM_ST_FAIL]) begin
					fail_output_q <= 1'b0;
					wd_fails_q <= 2'h0;
				end
			end
			// Supply flags other than overvoltage only after the first release
			if (released_q) begin
				if (warn_s)
					warn_flag_q <= 1'b1;
				if (uv_s)
					uv_flag_q <= 1'b1;
				if (vsuv_s)
					vsuv_flag_q <= 1'b1;
			end
			if (ov_rise)
				ov_flag_q <= 1'b1;
			// Watchdog counter
			if (!wd_run || wd_trig) begin
				wd_cnt_q <= {CW{1'b0}};
				if (wd_trig && wd_run)
					lw_q <= 1'b0;
			end else if (!wd_limit)
				wd_cnt_q <= wd_cnt_q + {{(CW-1){1'b0}}, 1'b1};
			// Reset output low phase
			if (!reset_out_low_pin_q) begin
				// Delay runs only in init and restart, afresh each time
				if (uv_s || (state_q != ST_INIT && state_q != ST_RESTART))
					rd_cnt_q <= {CW{1'b0}};
				else if (rd_cnt_q < RD_CYC[CW-1:0])
					rd_cnt_q <= rd_cnt_q + {{(CW-1){1'b0}}, 1'b1};
				if (state_q == ST_INIT)
					dev_mode_q <= test_s;
			end else begin
				rd_cnt_q <= {CW{1'b0}};
			end
			case (state_q)
				ST_INIT: begin
					if (!reset_out_low_pin_q) begin
						if (!uv_s && rd_cnt_q >= RD_CYC[CW-1:0]) begin
							reset_out_low_pin_q <= 1'b1;
							released_q <= 1'b1;
							lw_q <= 1'b1;
							strap_q <= flt_ok_q ? flt_val_q : 1'b0;
						end
					end else if (uv_s) begin
						state_q <= ST_RESTART;
					end else if (wd_fail) begin
						state_q <= ST_RESTART;
					end else if (frame_done_q) begin
						state_q <= ST_NORMAL;
					end
					// Wake inputs not looked at here
				end
				ST_NORMAL, ST_STOP: begin
					if (wr_mode) begin
						mode_field_q <= reg_wdata[1:0];
						if (reg_wdata[1:0] == `SBCM_MODE_SOFTRST) begin
							state_q <= ST_INIT;
							mode_field_q <= `SBCM_MODE_NORMAL;
							lw_q <= 1'b1;
							wd_cnt_q <= {CW{1'b0}};
							if (!locked) begin
								fcs_q <= `SBCM_RST_FCS;
								ov_en_q <= `SBCM_RST_OVEN;
							end
						end else if (reg_wdata[1:0] == `SBCM_MODE_SLEEP)
							state_q <= (state_q == ST_STOP) ? ST_RESTART : ST_SLEEP;
						else if (reg_wdata[1:0] == `SBCM_MODE_STOP)
							state_q <= ST_STOP;
						else
							state_q <= ST_NORMAL;
					end
					if (uv_s)
						state_q <= ST_RESTART;
				end
				ST_SLEEP: begin
					reset_out_low_pin_q <= 1'b0;
					if (wake_s)
						state_q <= ST_RESTART;
				end
				ST_RESTART: begin
					reset_out_low_pin_q <= 1'b0;
					mode_field_q <= `SBCM_MODE_NORMAL;
					if (uv_s || ov_s)
						rd_cnt_q <= {CW{1'b0}};
					else if (!reset_out_low_pin_q && rd_cnt_q >= RD_CYC[CW-1:0]) begin
						state_q <= ST_NORMAL;
						reset_out_low_pin_q <= 1'b1;
						lw_q <= 1'b1;
						if (por_flag_q)
							strap_q <= flt_ok_q ? flt_val_q : 1'b0;
					end
				end
				ST_FAILSAFE: begin
					reset_out_low_pin_q <= 1'b0;
					mode_field_q <= `SBCM_MODE_NORMAL;
					if (wake_s || (fs_by_ot_q && !ot_s)) begin
						state_q <= ST_RESTART;
						fs_by_ot_q <= 1'b0;
					end
				end
				default: begin
					state_q <= ST_RESTART;
				end
			endcase
			// Failure events override the mode request
			if (wd_fail && state_q != ST_INIT) begin
				wd_fails_q <= fails_nx;
				if (fcs_q || fails_nx == 2'h2)
					fail_output_q <= 1'b1;
				if (strap_q)
					state_q <= ST_RESTART;
				else if (fcs_q || fails_nx == 2'h2)
					state_q <= ST_FAILSAFE;
				else
					state_q <= ST_RESTART;
			end else if (wd_fail) begin
				wd_fails_q <= fails_nx;
				if (fcs_q)
					fail_output_q <= 1'b1;
			end
			if (ov_rise && ov_en_q) begin
				fail_output_q <= 1'b1;
				state_q <= strap_q ? ST_RESTART : ST_FAILSAFE;
			end
			if (ot_s && state_q != ST_FAILSAFE) begin
				state_q <= ST_FAILSAFE;
				fs_by_ot_q <= 1'b1;
			end
		end
	end

	// ----------------------------------------
	// Supply and peripheral outputs
	// ----------------------------------------
	always @(posedge sys_clk) begin
		if (rst) begin
			main_regulator_en_q <= 1'b1;
			aux_regulator_en_q <= 1'b0;
			can_force_normal_q <= 1'b0;
			wd_halted_q <= 1'b1;
			mode_state_q <= ST_INIT;
		end else begin
			main_regulator_en_q <= !(state_q == ST_SLEEP || state_q == ST_FAILSAFE);
			aux_regulator_en_q <= dev_mode_q;
			can_force_normal_q <= dev_mode_q;
			wd_halted_q <= !wd_run;
			mode_state_q <= state_q;
		end
	end

endmodule

//--- tb/sbcm_mode_ctrl_asserts.sv
// Concurrent checks on the mode controller ports
`timescale 1ns/1ps
module sbcm_mode_ctrl_asserts (
	input wire sys_clk,
	input wire rst,
	input wire [2:0] mode_state_q,
	input wire reset_out_low_pin_q,
	input wire irq_low_pin_out_q,
	input wire irq_low_pin_oe_n_q,
	input wire main_regulator_en_q,
	input wire aux_regulator_en_q,
	input wire can_force_normal_q,
	input wire wd_halted_q
);
	// ----------------------------------------
	// Clocking and sequences
	// ----------------------------------------
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (rst);
	// Reset output held low in init
	sequence s_held;
		(!reset_out_low_pin_q && mode_state_q == 3'h0) [*8];
	endsequence
	// Reset output released
	sequence s_release;
		reset_out_low_pin_q;
	endsequence
	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	AST_MODE_RANGE: assert property (mode_state_q <= 3'h5) else $error("mode code out of range");
	AST_POWERUP: assert property ($fell(rst) |-> s_held ##[1:30] s_release)
		else $error("reset output not released after delay");
	AST_RESTART_EXIT: assert property ($past(mode_state_q) == 3'h4 && mode_state_q != 3'h4
		|-> mode_state_q inside {3'h1, 3'h5}) else $error("restart left to wrong mode");
	AST_RESTART_RST: assert property ($rose(mode_state_q == 3'h4) |=> !reset_out_low_pin_q)
		else $error("restart without reset output");
	AST_FAILSAFE_REG: assert property ((mode_state_q == 3'h5) [*2] |-> !main_regulator_en_q)
		else $error("main regulator on in fail-safe");
	AST_FAILSAFE_EXIT: assert property ($past(mode_state_q) == 3'h5 && mode_state_q != 3'h5
		|-> mode_state_q == 3'h4) else $error("fail-safe left not via restart");
	AST_DEV_FORCES: assert property (aux_regulator_en_q |-> can_force_normal_q && wd_halted_q)
		else $error("development mode forces incomplete");
	AST_INIT_EXIT: assert property ($past(mode_state_q) == 3'h0 && mode_state_q != 3'h0
		|-> mode_state_q inside {3'h1, 3'h4, 3'h5}) else $error("init left to wrong mode");
	AST_PULLDOWN_VAL: assert property (!irq_low_pin_out_q) else $error("pull-down drives high");
	AST_PULLDOWN_OFF: assert property ($rose(reset_out_low_pin_q) |=> irq_low_pin_oe_n_q)
		else $error("pull-down kept after release");
endmodule
bind sbcm_mode_ctrl sbcm_mode_ctrl_asserts u_chk (.sys_clk(sys_clk), .rst(rst), .mode_state_q(mode_state_q),
	.reset_out_low_pin_q(reset_out_low_pin_q), .irq_low_pin_out_q(irq_low_pin_out_q),
	.irq_low_pin_oe_n_q(irq_low_pin_oe_n_q), .main_regulator_en_q(main_regulator_en_q),
	.aux_regulator_en_q(aux_regulator_en_q), .can_force_normal_q(can_force_normal_q), .wd_halted_q(wd_halted_q));

//--- tb/sbcm_host_model.sv
// Host model: serial frames, interrupt pin strap, test pin
`timescale 1ns/1ps
module sbcm_host_model (
	input wire irq_low_pin_oe_n_q,
	input wire pull_up,
	input wire dev_req,
	input wire spi_miso_q,
	output reg spi_clk_pin,
	output reg spi_cs_n_pin,
	output reg spi_mosi_pin,
	output wire irq_low_pin_in,
	output wire test_pin
);
	reg idle_q; // Wandering level of undriven lines
	reg [15:0] miso_word; // Bits read back in the last frame
	// External pull-up beats weak pull-down; a floating line wanders
	assign irq_low_pin_in = pull_up | (irq_low_pin_oe_n_q & idle_q);
	assign test_pin = dev_req;
	// Idle state: link clock still, select line high
	initial begin
		idle_q = 1'b0;
		miso_word = 16'h0000;
		spi_clk_pin = 1'b0;
		spi_cs_n_pin = 1'b1;
		spi_mosi_pin = 1'b0;
	end
	// Data line changes while no frame runs
	always #200 begin
		idle_q = ~idle_q;
		if (spi_cs_n_pin) begin
			spi_mosi_pin = idle_q;
		end
	end
	// One frame of n bits, most significant first, 400 ns link clock
	task frame(input [15:0] w, input integer n);
		integer i;
		begin
			#37 spi_cs_n_pin = 1'b0;
			for (i = 0; i < n; i = i + 1) begin
				spi_mosi_pin = w[15 - i];
				#200 spi_clk_pin = 1'b1;
				#200 miso_word = {miso_word[14:0], spi_miso_q};
				spi_clk_pin = 1'b0;
			end
			#200 spi_cs_n_pin = 1'b1;
			#400;
		end
	endtask
endmodule

//--- tb/testbench.sv
// Self-checking bench for the mode controller
`timescale 1ns/1ps
module testbench;
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	reg sys_clk = 1'b0; // Bench clock
	reg rst = 1'b1; // Power-on reset
	reg [3:0] reg_addr = 4'h0; // Register bus
	reg [7:0] reg_wdata = 8'h00;
	reg reg_wr = 1'b0;
	reg reg_rd = 1'b0;
	reg pull_up = 1'b1, dev_req = 1'b0; // Strap and test pin choice
	reg main_uv_pin = 1'b0, main_warn_pin = 1'b0, batt_uv_pin = 1'b0, main_ov_pin = 1'b0, overtemp_pin = 1'b0;
	reg wake_can_pin = 1'b0, wake_input_pin = 1'b0, wake_gpio_pin = 1'b0;
	wire [7:0] reg_rdata_q;
	wire [2:0] mode_state_q;
	wire irq_low_pin_in, irq_low_pin_out_q, irq_low_pin_oe_n_q, test_pin, spi_clk_pin, spi_cs_n_pin, spi_mosi_pin;
	wire spi_miso_q, reset_out_low_pin_q, fail_output_q, main_regulator_en_q, aux_regulator_en_q;
	wire can_force_normal_q, wd_halted_q;
	integer miscompares = 0, check_count = 0; // Score
	reg rd_q = 1'b0; // Read taken last edge
	reg [7:0] qe[$], qm[$]; // Expected read data and masks
	reg [7:0] e, m;
	reg [15:0] w; // Random frame word
	// ----------------------------------------
	// Design, host and clock
	// ----------------------------------------
	sbcm_mode_ctrl #(.LW_CYC(200), .WD_CYC(100), .RD_CYC(10), .CF_CYC(4)) uut (.sys_clk(sys_clk), .rst(rst),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
		.irq_low_pin_in(irq_low_pin_in), .irq_low_pin_out_q(irq_low_pin_out_q), .test_pin(test_pin),
		.irq_low_pin_oe_n_q(irq_low_pin_oe_n_q), .main_uv_pin(main_uv_pin), .main_warn_pin(main_warn_pin),
		.batt_uv_pin(batt_uv_pin), .main_ov_pin(main_ov_pin), .overtemp_pin(overtemp_pin),
		.wake_can_pin(wake_can_pin), .wake_input_pin(wake_input_pin), .wake_gpio_pin(wake_gpio_pin),
		.spi_clk_pin(spi_clk_pin), .spi_cs_n_pin(spi_cs_n_pin), .spi_mosi_pin(spi_mosi_pin), .spi_miso_q(spi_miso_q),
		.reset_out_low_pin_q(reset_out_low_pin_q), .fail_output_q(fail_output_q),
		.main_regulator_en_q(main_regulator_en_q), .aux_regulator_en_q(aux_regulator_en_q),
		.can_force_normal_q(can_force_normal_q), .wd_halted_q(wd_halted_q), .mode_state_q(mode_state_q));
	sbcm_host_model host (.irq_low_pin_oe_n_q(irq_low_pin_oe_n_q), .pull_up(pull_up), .dev_req(dev_req),
		.spi_clk_pin(spi_clk_pin), .spi_cs_n_pin(spi_cs_n_pin), .spi_mosi_pin(spi_mosi_pin),
		.irq_low_pin_in(irq_low_pin_in), .test_pin(test_pin), .spi_miso_q(spi_miso_q));
	always #25 sys_clk = ~sys_clk;
	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	// Compare and count
	task check(input string name, input [7:0] seen, input [7:0] exp);
		begin
			check_count = check_count + 1;
			if (seen !== exp) begin
				miscompares = miscompares + 1;
				$display("ERROR %0s expected %h seen %h", name, exp, seen);
			end
		end
	endtask
	// One-cycle register write
	task wr(input [3:0] a, input [7:0] d);
		begin
			@(posedge sys_clk);
			reg_addr <= a;
			reg_wdata <= d;
			reg_wr <= 1'b1;
			@(posedge sys_clk);
			reg_wr <= 1'b0;
		end
	endtask
	// One-cycle register read, expectation queued
	task rd(input [3:0] a, input [7:0] ex, input [7:0] mk);
		begin
			@(posedge sys_clk);
			reg_addr <= a;
			reg_rd <= 1'b1;
			qe.push_back(ex);
			qm.push_back(mk);
			@(posedge sys_clk);
			reg_rd <= 1'b0;
		end
	endtask
	// Bounded wait for a mode, then compare
	task wm(input [2:0] md, input integer n);
		integer i;
		begin
			for (i = 0; i < n && mode_state_q !== md; i = i + 1) begin
				@(posedge sys_clk);
				#1;
			end
			check("mode", {5'h00, mode_state_q}, {5'h00, md});
			// Leave on an edge so the next drive lands there
			@(posedge sys_clk);
		end
	endtask
	// Power-up with a strap and test pin choice
	task power(input p, input d);
		integer i;
		begin
			@(posedge sys_clk);
			pull_up <= p;
			dev_req <= d;
			rst <= 1'b1;
			repeat (4) @(posedge sys_clk);
			rst <= 1'b0;
			@(posedge sys_clk);
			#1;
			check("pulldown", {7'h00, irq_low_pin_oe_n_q}, 8'h00);
			for (i = 0; i < 40 && reset_out_low_pin_q !== 1'b1; i = i + 1) begin
				@(posedge sys_clk);
				#1;
			end
			check("rstout", {7'h00, reset_out_low_pin_q}, 8'h01);
			@(posedge sys_clk);
		end
	endtask
	// Verdict and end of run
	task test_done;
		begin
			$display("checks %0d mismatches %0d", check_count, miscompares);
			if (miscompares == 0 && check_count > 0)
				$display("RESULT: PASS");
			else
				$display("RESULT: FAIL");
			$finish;
		end
	endtask
	// Read monitor: oldest note against read data
	always @(posedge sys_clk) begin
		if (rd_q) begin
			e = qe.pop_front();
			m = qm.pop_front();
			check("rdata", reg_rdata_q & m, e & m);
		end
		rd_q <= reg_rd;
	end
	// Watchdog on the whole run
	initial begin
		#2000000;
		miscompares = miscompares + 1;
		test_done;
	end
	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial begin
		void'($urandom(32'hF2904AE2));
		w = $urandom;
		// Strap one: frame, registers, overvoltage, overtemperature, watchdog
		power(1'b1, 1'b0);
		host.frame(w, 16);
		wm(3'h1, 20);
		check("miso_hi", host.miso_word[15:8], 8'h00);
		check("miso_lo", host.miso_word[7:0], 8'h01);
		wr(4'h5, w[7:0]);
		{main_warn_pin, batt_uv_pin} <= w[9:8];
		rd(4'h3, 8'h01, 8'h01);
		rd(4'h1, 8'h00, 8'h03);
		rd(4'h6 + w[11:10], 8'h00, 8'hFF);
		rd(4'h2, 8'h01, 8'h01);
		wr(4'h1, 8'h01);
		rd(4'h1, 8'h01, 8'h03);
		main_ov_pin <= 1'b1;
		repeat (10) @(posedge sys_clk);
		main_ov_pin <= 1'b0;
		check("fail", {7'h00, fail_output_q}, 8'h00);
		wm(3'h1, 1);
		rd(4'h2, 8'h02, 8'h22);
		wr(4'h2, 8'h02);
		wr(4'h1, 8'h03);
		wr(4'h5, 8'h00);
		wr(4'h0, 8'h02);
		wm(3'h2, 10);
		rd(4'h0, 8'h02, 8'h03);
		main_ov_pin <= 1'b1;
		wm(3'h4, 10);
		check("fail", {7'h00, fail_output_q}, 8'h01);
		main_ov_pin <= 1'b0;
		wm(3'h1, 60);
		rd(4'h0, 8'h00, 8'h03);
		overtemp_pin <= 1'b1;
		wm(3'h5, 10);
		check("mainreg", {7'h00, main_regulator_en_q}, 8'h00);
		overtemp_pin <= 1'b0;
		wm(3'h1, 60);
		wr(4'h2, 8'h20);
		wm(3'h4, 300);
		check("fail", {7'h00, fail_output_q}, 8'h01);
		$display("test strap_one done");
		// Strap zero: wakes ignored in init, two missed windows
		power(1'b0, 1'b0);
		{wake_can_pin, wake_input_pin, wake_gpio_pin} <= 3'h7;
		repeat (4) @(posedge sys_clk);
		{wake_can_pin, wake_input_pin, wake_gpio_pin} <= 3'h0;
		repeat (4) @(posedge sys_clk);
		wm(3'h0, 1);
		rd(4'h3, 8'h00, 8'h01);
		wm(3'h4, 260);
		check("fail", {7'h00, fail_output_q}, 8'h00);
		wm(3'h1, 60);
		wm(3'h5, 300);
		check("fail", {7'h00, fail_output_q}, 8'h01);
		wake_input_pin <= 1'b1;
		repeat (4) @(posedge sys_clk);
		wake_input_pin <= 1'b0;
		wm(3'h1, 80);
		$display("test strap_zero done");
		// Development mode: short frame, halted watchdog, soft reset
		power(w[12], 1'b1);
		check("devforce", {5'h00, aux_regulator_en_q, can_force_normal_q, wd_halted_q}, 8'h07);
		host.frame(w, 15);
		wm(3'h0, 1);
		repeat (250) @(posedge sys_clk);
		wm(3'h0, 1);
		host.frame(w, 16);
		wm(3'h1, 20);
		check("miso_lo", host.miso_word[7:0], {6'h00, 1'b1, w[12]});
		rd(4'h3, 8'h02, 8'h02);
		wr(4'h1, 8'h01);
		wr(4'h0, 8'h03);
		wm(3'h0, 10);
		rd(4'h1, 8'h00, 8'h01);
		repeat (3) @(posedge sys_clk);
		$display("test development done");
		test_done;
	end
endmodule
